// File: pkg/aocl_map.vh
// Register map, field positions, reset values and timing counts for the offset clamp loop.
// Assumes an APB slave with 32-bit data; a register's byte address is four times its index.
// Functional notes
// - Hold bit freezes offset in automatic mode, stops loop updates.
// - Bit 7: manual offset, or automatic toward target.
// - Rate field: every clamp, 16, 64, vsync.
// - Shift field scales error: full, half, quarter, eighth.
// - Jump mode: error above 15 sets offset directly.
// - Post filter needs six consecutive change votes.
// - Toggle filter holds offset after back-and-forth pattern.
// - Slew limit register caps each step except jumps, resets eight.
// - Measure mode 0 samples during clamp.
// - Measure mode 1: six clocks after 10/16 delay.
`ifndef AOCL_MAP_VH
`define AOCL_MAP_VH

// Register indices and byte addresses.
`define AOCL_IDX_HOLD      8'h1B
`define AOCL_IDX_CTRL      8'h1C
`define AOCL_IDX_SLEW      8'h1D
`define AOCL_IDX_MEAS      8'h21
`define AOCL_IDX_TARGET    8'h40
`define AOCL_IDX_STATUS    8'h41
`define AOCL_ADDR_HOLD     12'h06C
`define AOCL_ADDR_CTRL     12'h070
`define AOCL_ADDR_SLEW     12'h074
`define AOCL_ADDR_MEAS     12'h084
`define AOCL_ADDR_TARGET   12'h100
`define AOCL_ADDR_STATUS   12'h104

// Reset values.
`define AOCL_RST_HOLD      8'h00
`define AOCL_RST_CTRL      8'h4E
`define AOCL_RST_SLEW      8'h08
`define AOCL_RST_MEAS      8'h0C
`define AOCL_RST_TARGET    8'h00

// Field positions.
`define AOCL_B_HOLD        0
`define AOCL_B_AUTO        7
`define AOCL_F_RATE_HI     6
`define AOCL_F_RATE_LO     5
`define AOCL_F_SHIFT_HI    4
`define AOCL_F_SHIFT_LO    3
`define AOCL_B_JUMP        2
`define AOCL_B_POST        1
`define AOCL_B_TOGGLE      0
`define AOCL_B_MMODE       3
`define AOCL_B_MLEN        2

// Update rate codes.
`define AOCL_RATE_CLAMP    2'h0
`define AOCL_RATE_16       2'h1
`define AOCL_RATE_64       2'h2
`define AOCL_RATE_VSYNC    2'h3

// Counts in clocks, clamps or votes, plus the jump limit, divide-by-six constants and code ceiling.
`define AOCL_N_16          7'h10
`define AOCL_N_64          7'h40
`define AOCL_DLY_SHORT     5'h0A
`define AOCL_DLY_LONG      5'h10
`define AOCL_WIN_LEN       3'h6
`define AOCL_VOTES         3'h6
`define AOCL_JUMP_LIM      10'h00F
`define AOCL_RECIP6        11'h0AB
`define AOCL_RECIP_SH      10
`define AOCL_CODE_MAX      10'h0FF

`endif

// File: logic/aocl_loop.v
// Automatic black-level offset loop for one video channel, with its APB register file.
// Assumes clampActive, vsyncPulse and sampleCode are synchronous to the pixel clock clk.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "aocl_map.vh"

module aocl_loop (
   input  wire        clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   input  wire        clampActive,
   input  wire        vsyncPulse,
   input  wire [7:0]  sampleCode,
   output wire [7:0]  offsetOut
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_DELAY = 2'h1;
   localparam ST_WIN   = 2'h2;

   reg  [7:0]  holdReg_r, ctrlReg_r, slewReg_r, measReg_r, targetReg_r;
   reg  [7:0]  offset_r;
   reg  [7:0]  meas_r;
   reg         measValid_r;
   reg         clampPrev_r;
   reg  [1:0]  mState_r;
   reg  [4:0]  mCnt_r;
   reg  [10:0] mSum_r;
   reg  [6:0]  rateCnt_r;
   reg  [2:0]  vote_r;
   reg  [1:0]  lastDir_r;
   reg         toggled_r;
   reg         measDone;
   reg  [7:0]  measNow;
   reg         updateNow;
   reg  [9:0]  step;
   reg  [9:0]  newOff;
   reg         applyNow;

   wire        apbWr   = psel & penable & pwrite;
   wire        apbSet  = psel & ~penable;
   wire        autoOn  = ctrlReg_r[`AOCL_B_AUTO];
   wire        holdOn  = holdReg_r[`AOCL_B_HOLD];
   wire [1:0]  rate    = ctrlReg_r[`AOCL_F_RATE_HI:`AOCL_F_RATE_LO];
   wire [1:0]  shAmt   = ctrlReg_r[`AOCL_F_SHIFT_HI:`AOCL_F_SHIFT_LO];
   wire        clampEnd = clampPrev_r & ~clampActive;
   wire [4:0]  dlyLen  = measReg_r[`AOCL_B_MLEN] ? `AOCL_DLY_LONG : `AOCL_DLY_SHORT;
   wire [21:0] avgProd = mSum_r * `AOCL_RECIP6;
   // The measurement that finishes in this cycle drives its own update, not the one before.
   wire [7:0]  measUse = measDone ? measNow : meas_r;
   wire [9:0]  err     = {2'h0, targetReg_r} - {2'h0, measUse};
   wire [9:0]  errMag  = err[9] ? (10'h000 - err) : err;
   wire [9:0]  errSh   = $signed(err) >>> shAmt;
   wire [9:0]  slewPos = {2'h0, slewReg_r};
   wire [9:0]  slewNeg = 10'h000 - slewPos;

   // Address decode used only for the pslverr response.
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `AOCL_ADDR_HOLD) || (a == `AOCL_ADDR_CTRL) ||
                  (a == `AOCL_ADDR_SLEW) || (a == `AOCL_ADDR_MEAS) ||
                  (a == `AOCL_ADDR_TARGET) || (a == `AOCL_ADDR_STATUS);
      end
   endfunction

   // Zero wait states keep the bus simple; every access completes in its access cycle.
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped(paddr);
   assign offsetOut = offset_r;

   // Register writes take effect only in the access cycle.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         holdReg_r   <= `AOCL_RST_HOLD;
         ctrlReg_r   <= `AOCL_RST_CTRL;
         slewReg_r   <= `AOCL_RST_SLEW;
         measReg_r   <= `AOCL_RST_MEAS;
         targetReg_r <= `AOCL_RST_TARGET;
      end else if (apbWr) begin
         case (paddr)
            `AOCL_ADDR_HOLD:   holdReg_r   <= pwdata[7:0];
            `AOCL_ADDR_CTRL:   ctrlReg_r   <= pwdata[7:0];
            `AOCL_ADDR_SLEW:   slewReg_r   <= pwdata[7:0];
            `AOCL_ADDR_MEAS:   measReg_r   <= pwdata[7:0];
            `AOCL_ADDR_TARGET: targetReg_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read data is latched in the setup cycle so it comes straight from a flip-flop.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (apbSet) begin
         case (paddr)
            `AOCL_ADDR_HOLD:   prdata <= {24'h000000, holdReg_r};
            `AOCL_ADDR_CTRL:   prdata <= {24'h000000, ctrlReg_r};
            `AOCL_ADDR_SLEW:   prdata <= {24'h000000, slewReg_r};
            `AOCL_ADDR_MEAS:   prdata <= {24'h000000, measReg_r};
            `AOCL_ADDR_TARGET: prdata <= {24'h000000, targetReg_r};
            `AOCL_ADDR_STATUS: prdata <= {14'h0000, toggled_r, measValid_r,
                                          meas_r, offset_r};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Measurement sequencer: in-clamp sampling, or a delayed six-clock average.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         clampPrev_r <= 1'b0;
         mState_r    <= ST_IDLE;
         mCnt_r      <= 5'h00;
         mSum_r      <= 11'h000;
         meas_r      <= 8'h00;
         measValid_r <= 1'b0;
      end else begin
         clampPrev_r <= clampActive;
         if (measDone) begin
            meas_r      <= measNow;
            measValid_r <= 1'b1;
         end
         case (mState_r)
            ST_IDLE: begin
               if (clampActive && !measReg_r[`AOCL_B_MMODE])
                  mSum_r <= {3'h0, sampleCode};
               if (clampEnd && measReg_r[`AOCL_B_MMODE]) begin
                  mState_r <= ST_DELAY;
                  mCnt_r   <= 5'h01;
               end
            end
            ST_DELAY: begin
               if (mCnt_r == dlyLen) begin
                  mState_r <= ST_WIN;
                  mCnt_r   <= 5'h01;
                  mSum_r   <= {3'h0, sampleCode};
               end else begin
                  mCnt_r <= mCnt_r + 5'h01;
               end
            end
            ST_WIN: begin
               if (mCnt_r == {2'h0, `AOCL_WIN_LEN}) begin
                  mState_r <= ST_IDLE;
               end else begin
                  mCnt_r <= mCnt_r + 5'h01;
                  mSum_r <= mSum_r + {3'h0, sampleCode};
               end
            end
            default: mState_r <= ST_IDLE;
         endcase
      end
   end

   // Completion of one measurement and its result.
   always @* begin
      measDone = 1'b0;
      measNow  = mSum_r[7:0];
      if (!measReg_r[`AOCL_B_MMODE]) begin
         measDone = clampEnd;
      end else if (mState_r == ST_WIN && mCnt_r == {2'h0, `AOCL_WIN_LEN}) begin
         measDone = 1'b1;
         measNow  = avgProd[`AOCL_RECIP_SH+7:`AOCL_RECIP_SH];
      end
   end

   // Update pacing in clamps or frames.
   always @* begin
      case (rate)
         `AOCL_RATE_CLAMP: updateNow = measDone;
         `AOCL_RATE_16:    updateNow = measDone && (rateCnt_r == `AOCL_N_16 - 7'h01);
         `AOCL_RATE_64:    updateNow = measDone && (rateCnt_r == `AOCL_N_64 - 7'h01);
         `AOCL_RATE_VSYNC: updateNow = vsyncPulse && measValid_r;
         default:          updateNow = 1'b0;
      endcase
   end

   // Correction: jump for large errors, otherwise scaled and slew-limited step.
   always @* begin
      step = errSh;
      if (ctrlReg_r[`AOCL_B_JUMP] && errMag > `AOCL_JUMP_LIM) begin
         step = err;
      end else if (!errSh[9] && errSh > slewPos) begin
         step = slewPos;
      end else if (errSh[9] && $signed(errSh) < $signed(slewNeg)) begin
         step = slewNeg;
      end
      newOff = {2'h0, offset_r} + step;
      if (step[9] && newOff[9])
         newOff = 10'h000;
      else if (!step[9] && newOff > `AOCL_CODE_MAX)
         newOff = `AOCL_CODE_MAX;
      // Six votes in a row are needed when the post filter is on.
      applyNow = autoOn && !holdOn && updateNow && step != 10'h000 &&
                 !(ctrlReg_r[`AOCL_B_TOGGLE] && toggled_r) &&
                 (!ctrlReg_r[`AOCL_B_POST] || vote_r == `AOCL_VOTES - 3'h1);
   end

   // Offset state and filters. The toggle latch clears only when its filter is disabled.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         offset_r  <= 8'h00;
         rateCnt_r <= 7'h00;
         vote_r    <= 3'h0;
         lastDir_r <= 2'h0;
         toggled_r <= 1'b0;
      end else begin
         if (measDone)
            rateCnt_r <= updateNow ? 7'h00 : rateCnt_r + 7'h01;
         if (!autoOn) begin
            offset_r <= targetReg_r;
            vote_r   <= 3'h0;
         end else if (updateNow && !holdOn) begin
            if (step == 10'h000 || applyNow)
               vote_r <= 3'h0;
            else
               vote_r <= vote_r + 3'h1;
            if (applyNow) begin
               offset_r  <= newOff[7:0];
               lastDir_r <= {1'b1, step[9]};
               if (lastDir_r[1] && lastDir_r[0] != step[9])
                  toggled_r <= 1'b1;
            end
         end
         if (!ctrlReg_r[`AOCL_B_TOGGLE]) begin
            toggled_r <= 1'b0;
            if (!applyNow)
               lastDir_r <= 2'h0;
         end
      end
   end

endmodule // aocl_loop

// File: test/aocl_loop_chk.sv
// Checker for the offset clamp loop: APB answers and how the offset may move.
// Assumes it is bound to aocl_loop and sees nothing but that module's ports.
`timescale 1ns/1ps
`include "aocl_map.vh"
module aocl_loop_chk (
   input wire        clk,
   input wire        rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   input wire [31:0] prdata,
   input wire        clampActive,
   input wire        vsyncPulse,
   input wire [7:0]  sampleCode,
   input wire [7:0]  offsetOut
);
   logic       acc, wr, mapped, autoR, jumpR, holdR;
   logic [7:0] slewR;
   logic [5:0] evAge;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Access decode, shared by the shadow registers and the bus properties.
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign mapped = paddr inside {`AOCL_ADDR_HOLD, `AOCL_ADDR_CTRL, `AOCL_ADDR_SLEW,
                                 `AOCL_ADDR_MEAS, `AOCL_ADDR_TARGET, `AOCL_ADDR_STATUS};
   // Shadow copies of the loop controls, taken at the edge where a write lands.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         {autoR, jumpR, holdR} <= 3'h2;
         slewR <= `AOCL_RST_SLEW;
      end else if (wr) begin
         if (paddr == `AOCL_ADDR_CTRL) {autoR, jumpR} <= {pwdata[7], pwdata[2]};
         if (paddr == `AOCL_ADDR_HOLD) holdR <= pwdata[0];
         if (paddr == `AOCL_ADDR_SLEW) slewR <= pwdata[7:0];
      end
   end
   // Cycles since the last measurement trigger; it saturates so it never wraps.
   always @(posedge clk or posedge rst) begin
      if (rst) evAge <= 6'h3F;
      else if ($fell(clampActive) || vsyncPulse) evAge <= 6'h00;
      else if (evAge != 6'h3F) evAge <= evAge + 6'h01;
   end
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_map: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
   a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
   a_hold_freeze: assert property (holdR && $past(holdR) && autoR |-> $stable(offsetOut))
      else $error("offset moved under hold");
   a_manual_follow: assert property (wr && paddr == `AOCL_ADDR_TARGET && !autoR
      |-> ##2 {24'h000000, offsetOut} == ($past(pwdata, 2) & 32'h000000FF))
      else $error("manual offset not applied");
   a_manual_quiet: assert property (!autoR && !$past(wr) && !$past(wr, 2)
      |-> $stable(offsetOut)) else $error("offset moved in manual mode");
   a_slew_cap: assert property (autoR && !jumpR |-> (offsetOut >= $past(offsetOut) ?
      offsetOut - $past(offsetOut) : $past(offsetOut) - offsetOut) <= slewR)
      else $error("offset step above slew limit");
   a_move_on_event: assert property (autoR && $past(autoR) && !$stable(offsetOut)
      |-> evAge < 6'h1E) else $error("offset moved with no measurement");
   c_hold: cover property (holdR && autoR && $fell(clampActive));
   c_unmapped: cover property (acc && !mapped);
   c_step: cover property (autoR && !$stable(offsetOut));
endmodule // aocl_loop_chk

bind aocl_loop aocl_loop_chk i_aocl_loop_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .prdata, .clampActive, .vsyncPulse, .sampleCode, .offsetOut);

// File: test/aocl_tb.sv
// Self-checking bench for the offset clamp loop, driven over APB and the clamp inputs.
// Assumes zero-wait APB answers and that the register map header is on the include path.
`timescale 1ns/1ps
`include "aocl_map.vh"
module tb;
   logic        clk, rst, psel, penable, pwrite, clampActive, vsyncPulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdata;
   logic        slvErr;
   logic [7:0]  sampleCode, x, prev;
   wire         pready, pslverr;
   wire  [31:0] prdata;
   wire  [7:0]  offsetOut;
   int          miscompares = 0;
   int          totalChecks = 0;
   int          ch;
   aocl_loop i_aocl_loop (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .pslverr, .prdata, .clampActive, .vsyncPulse, .sampleCode, .offsetOut);
   // Free-running pixel clock, 8 ns period.
   always #4 clk = ~clk;
   task automatic chk(input [31:0] got, input [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; an idle edge follows so the next setup never collides with release.
   task automatic apb(input logic w, input [11:0] a, input [7:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      slvErr = pslverr;
      {psel, penable} <= 2'h0;
      @(posedge clk);
   endtask
   task automatic rd(input [11:0] a, input [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(rdata, e);
   endtask
   // Clamp of four cycles, then code w in the six cycles from d clocks after it, zero elsewhere.
   task automatic clamp(input [7:0] c, input [7:0] w, input int d);
      {clampActive, sampleCode} <= {1'b1, c};
      repeat (4) @(posedge clk);
      clampActive <= 1'b0;
      for (int k = 0; k < 40; k++) begin
         sampleCode <= (k >= d && k < d + 6) ? w : 8'h00;
         @(posedge clk);
      end
   endtask
   task automatic cl(input [7:0] c, input [7:0] w, input int d, input [7:0] e);
      clamp(c, w, d);
      x = e;
      chk(offsetOut, e);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog: the full sequence needs about 8400 cycles.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      {clk, psel, penable, pwrite, clampActive, vsyncPulse, paddr, pwdata, sampleCode} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(`AOCL_ADDR_CTRL, 32'h0000004E);
      rd(`AOCL_ADDR_SLEW, 32'h00000008);
      rd(`AOCL_ADDR_HOLD, 32'h00000000);
      rd(12'hFF0, 32'h00000000);
      chk(slvErr, 32'h00000001);
      apb(1'b1, `AOCL_ADDR_TARGET, 8'h40);
      apb(1'b1, `AOCL_ADDR_MEAS, 8'h00);
      chk(offsetOut, 32'h00000040);
      x = 8'h40;
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, `AOCL_ADDR_CTRL, {3'h4, s[1:0], 3'h0});
         cl(8'h3C, 8'h00, 99, x + (8'h04 >> s));
      end
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h80);
      apb(1'b1, `AOCL_ADDR_SLEW, 8'h03);
      cl(8'h30, 8'h00, 99, 8'h4A);
      cl(8'h50, 8'h00, 99, 8'h47);
      apb(1'b1, `AOCL_ADDR_SLEW, 8'h08);
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h84);
      cl(8'h20, 8'h00, 99, 8'h67);
      cl(8'h31, 8'h00, 99, 8'h6F);
      apb(1'b1, `AOCL_ADDR_TARGET, 8'hFF);
      cl(8'h00, 8'h00, 99, 8'hFF);
      apb(1'b1, `AOCL_ADDR_TARGET, 8'h00);
      cl(8'hFF, 8'h00, 99, 8'h00);
      cl(8'hFF, 8'h00, 99, 8'h00);
      apb(1'b1, `AOCL_ADDR_TARGET, 8'h40);
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h80);
      apb(1'b1, `AOCL_ADDR_HOLD, 8'h01);
      cl(8'h3C, 8'h00, 99, 8'h00);
      apb(1'b1, `AOCL_ADDR_HOLD, 8'h00);
      for (int r = 1; r < 4; r++) begin
         apb(1'b1, `AOCL_ADDR_CTRL, {1'b1, r[1:0], 5'h00});
         ch = 0;
         for (int i = 0; i < ((r == 1) ? 32 : (r == 2) ? 128 : 3); i++) begin
            prev = offsetOut;
            clamp(8'h3C, 8'h00, 99);
            if (offsetOut !== prev) ch++;
         end
         chk(ch, (r < 3) ? 2 : 0);
      end
      vsyncPulse <= 1'b1;
      @(posedge clk);
      vsyncPulse <= 1'b0;
      repeat (3) @(posedge clk);
      x = 8'h14;
      chk(offsetOut, x);
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h80);
      for (int n = 0; n < 2; n++) begin
         apb(1'b1, `AOCL_ADDR_MEAS, {5'h01, n[0], 2'h0});
         cl(8'h00, 8'h3C, n ? 16 : 10, x + 8'h04);
      end
      apb(1'b1, `AOCL_ADDR_MEAS, 8'h00);
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h82);
      cl(8'h40, 8'h00, 99, x);
      for (int i = 0; i < 6; i++) cl(8'h3C, 8'h00, 99, (i == 5) ? x + 8'h04 : x);
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h81);
      cl(8'h3C, 8'h00, 99, x + 8'h04);
      cl(8'h44, 8'h00, 99, x - 8'h04);
      cl(8'h3C, 8'h00, 99, x);
      rd(`AOCL_ADDR_STATUS, 32'h00033C20);
      apb(1'b1, `AOCL_ADDR_CTRL, 8'h80);
      cl(8'h3C, 8'h00, 99, x + 8'h04);
      report_and_stop();
   end
endmodule // tb
